// [verilog/ecs_event_unit.v]
// Behaviour
// RQ1: Every event source has a fixed priority and simultaneous events resolve to the highest.
// RQ2: A pending higher class preempts the handling of a lower class.
// RQ3: Each class has its own return address and status storage, filled without memory writes.
// RQ4: Four external interrupt levels are accepted, each running in its own mode.
// RQ5: The outside controller arbitrates its sources and presents the winner with its vector.
// RQ6: In stack mode an interrupt entry pushes status, return address and the scratch group.
// RQ7: In stack mode an interrupt return pops the scratch group and status and resumes there.
// RQ8: In stack mode exceptions and supervisor calls push and pop status and return address.
// RQ9: In dedicated mode status and return address go to class registers, never the stack.
// RQ10: In dedicated mode call and return instructions touch no memory at all.
// RQ11: The top interrupt level has a banked scratch group so its handler starts at once; the code banks it in dedicated mode only, stack mode pushes it.
// RQ12: The register file holds sixteen 32-bit words including program counter, link and stack.
// RQ13: The mode field encodes the eight classes and reads supervisor after reset.
// RQ14: Entering level N sets the masks of level N and every lower level; all clear at reset.
// RQ15: Entering an exception or debug sets the exception mask, which is set at reset.
// RQ16: Only the scratch group is banked for the top level; all else is shared.
// RQ17: An event return restores mode and masks from the saved status of the current class.
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/10ps
`include "ecs_defines.vh"

module ecs_event_unit (
  pclk,
  presetn,
  paddr,
  psel,
  penable,
  pwrite,
  pwdata,
  prdata,
  pready,
  pslverr,
  irq_level_zero,
  irq_level_one,
  irq_level_two,
  irq_level_three,
  irq_vector,
  exc_req,
  nmi_req,
  scall_req,
  ret_req,
  dbg_enter,
  cur_pc,
  rf_we,
  rf_waddr,
  rf_wdata,
  rf_raddr,
  rf_rdata,
  mem_req,
  mem_we,
  mem_addr,
  mem_wdata,
  mem_rdata,
  mem_ack,
  core_stall,
  redirect_valid,
  redirect_pc,
  exec_mode,
  irq
);
  input wire pclk;
  input wire presetn;
  input wire [11:0] paddr;
  input wire psel;
  input wire penable;
  input wire pwrite;
  input wire [31:0] pwdata;
  output reg [31:0] prdata;
  output reg pready;
  output reg pslverr;
  input wire irq_level_zero;
  input wire irq_level_one;
  input wire irq_level_two;
  input wire irq_level_three;
  input wire [31:0] irq_vector;
  input wire exc_req;
  input wire nmi_req;
  input wire scall_req;
  input wire ret_req;
  input wire dbg_enter;
  input wire [31:0] cur_pc;
  input wire rf_we;
  input wire [3:0] rf_waddr;
  input wire [31:0] rf_wdata;
  input wire [3:0] rf_raddr;
  output wire [31:0] rf_rdata;
  output reg mem_req;
  output reg mem_we;
  output reg [31:0] mem_addr;
  output reg [31:0] mem_wdata;
  input wire [31:0] mem_rdata;
  input wire mem_ack;
  output reg core_stall;
  output reg redirect_valid;
  output reg [31:0] redirect_pc;
  output reg [2:0] exec_mode;
  output reg irq;

  localparam [3:0] S_IDLE = 4'd0;
  localparam [3:0] S_RDSP = 4'd1;
  localparam [3:0] S_GETSP = 4'd2;
  localparam [3:0] S_PREP = 4'd3;
  localparam [3:0] S_WAITRF = 4'd4;
  localparam [3:0] S_MEMW = 4'd5;
  localparam [3:0] S_MEMR = 4'd6;
  localparam [3:0] S_SPWR = 4'd7;
  localparam [3:0] S_DONE = 4'd8;

  reg [3:0] state_reg;
  reg [31:0] ctrl_reg;
  reg [31:0] sr_reg;
  reg [31:0] evba_reg;
  reg [`ECS_EV_WIDTH-1:0] istat_reg;
  reg [`ECS_EV_WIDTH-1:0] ien_reg;
  reg [2:0] pend_mode_reg;
  reg ret_flag_reg;
  reg nested_reg;
  reg [31:0] saved_sr_reg;
  reg [31:0] ra_reg;
  reg [31:0] sp_reg;
  reg [2:0] k_reg;
  wire [2:0] cur_mode = sr_reg[`ECS_SR_MODE_LSB+2:`ECS_SR_MODE_LSB];
  wire stack_mode = ctrl_reg[`ECS_CTRL_STACK];
  wire win_valid;
  wire [2:0] win_mode;
  wire [2:0] cls_idx = cur_mode - 3'd1;
  wire ret_ok = ret_req && cur_mode != `ECS_MODE_APP;
  wire take_evt = state_reg == S_IDLE && win_valid;
  wire take_ret = state_reg == S_IDLE && !win_valid && ret_ok;
  wire apb_wr = psel && penable && pready && pwrite;

  ////////////////////////////////////////////////////////////////////////////
  // Priority selection of the next event
  ecs_arbiter u_arb (
    .nmi_req(nmi_req),
    .exc_req(exc_req),
    .irq_levels({irq_level_three, irq_level_two, irq_level_one, irq_level_zero}), // RQ4
    .scall_req(scall_req),
    .exception_mask_bit(sr_reg[`ECS_SR_EM]),
    .irq_masks(sr_reg[`ECS_SR_IMASK_LSB+3:`ECS_SR_IMASK_LSB]),
    .cur_mode(cur_mode),
    .win_valid(win_valid),
    .win_mode(win_mode)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Per-class return status and address, written straight from the core
  wire [32*7-1:0] rsr_flat;
  wire [32*7-1:0] rar_flat;
  genvar g;
  generate
    for (g = 0; g < 7; g = g + 1) begin : gen_cls
      reg [31:0] rsr_reg;
      reg [31:0] rar_reg;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          rsr_reg <= 32'h0000_0000;
          rar_reg <= 32'h0000_0000;
        end else if (take_evt && !stack_mode && win_mode == g + 1) begin // RQ3 RQ9
          rsr_reg <= sr_reg;
          rar_reg <= cur_pc;
        end
      end
      assign rsr_flat[32*g +: 32] = rsr_reg;
      assign rar_flat[32*g +: 32] = rar_reg;
    end
  endgenerate
  wire [31:0] rsr_sel = rsr_flat[32*cls_idx +: 32];
  wire [31:0] rar_sel = rar_flat[32*cls_idx +: 32];

  ////////////////////////////////////////////////////////////////////////////
  // Register file port: the sequencer owns it while busy
  reg fsm_we;
  reg [3:0] fsm_waddr;
  reg [31:0] fsm_wdata;
  reg [3:0] fsm_raddr;
  wire is_irq_cls = pend_mode_reg >= `ECS_MODE_IRQ_LEVEL_ZERO && pend_mode_reg <= `ECS_MODE_IRQ_LEVEL_THREE;
  wire [2:0] frame_last = (is_irq_cls ? `ECS_FRAME_IRQ : `ECS_FRAME_EXC) - 3'd1;
  wire shadow_sel = !stack_mode && cur_mode == `ECS_MODE_IRQ_LEVEL_THREE; // RQ11
  wire busy = state_reg != S_IDLE;

  always @* begin
    fsm_we = 1'b0;
    fsm_waddr = `ECS_RF_SP;
    fsm_wdata = sp_reg;
    fsm_raddr = (state_reg == S_RDSP) ? `ECS_RF_SP : (4'd6 + {1'b0, k_reg});
    if (state_reg == S_MEMR && mem_ack && k_reg >= 3'd2) begin
      fsm_we = 1'b1; // RQ7
      fsm_waddr = 4'd6 + {1'b0, k_reg};
      fsm_wdata = mem_rdata;
    end else if (state_reg == S_SPWR) begin
      fsm_we = 1'b1;
    end
  end

  ecs_regfile u_rf (
    .pclk(pclk),
    .presetn(presetn),
    .shadow_sel(shadow_sel),
    .we(busy ? fsm_we : rf_we),
    .waddr(busy ? fsm_waddr : rf_waddr),
    .wdata(busy ? fsm_wdata : rf_wdata),
    .raddr(busy ? fsm_raddr : rf_raddr),
    .rdata(rf_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Status word update on entry and return
  wire fin_entry = (take_evt && !stack_mode) || (state_reg == S_SPWR && !ret_flag_reg);
  wire fin_ret = (take_ret && !stack_mode) || (state_reg == S_SPWR && ret_flag_reg);
  wire [2:0] entry_mode = (state_reg == S_IDLE) ? win_mode : pend_mode_reg;
  reg [31:0] entry_sr;
  integer j;

  always @* begin
    entry_sr = sr_reg;
    entry_sr[`ECS_SR_MODE_LSB+2:`ECS_SR_MODE_LSB] = entry_mode; // RQ13
    for (j = 0; j < 4; j = j + 1) begin
      if (entry_mode >= `ECS_MODE_IRQ_LEVEL_ZERO + j[2:0] && entry_mode <= `ECS_MODE_IRQ_LEVEL_THREE) begin
        entry_sr[`ECS_SR_IMASK_LSB + j] = 1'b1; // RQ14
      end
    end
    if (entry_mode == `ECS_MODE_EXC) begin
      entry_sr[`ECS_SR_EM] = 1'b1; // RQ15
    end
  end

  // Hardware updates win over a software write in the same cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sr_reg <= `ECS_SR_RESET; // RQ13 RQ14 RQ15
    end else begin
      if (fin_entry) begin
        sr_reg <= entry_sr;
      end else if (fin_ret) begin
        sr_reg <= stack_mode ? saved_sr_reg : rsr_sel; // RQ17
      end else if (apb_wr && paddr == `ECS_OFS_SR) begin
        sr_reg <= (sr_reg & ~`ECS_SR_SW_MASK) | (pwdata & `ECS_SR_SW_MASK);
      end
      if (dbg_enter) begin
        sr_reg[`ECS_SR_EM] <= 1'b1; // RQ15
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Entry and return sequencer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= S_IDLE;
      pend_mode_reg <= `ECS_MODE_SUP;
      ret_flag_reg <= 1'b0;
      nested_reg <= 1'b0;
      saved_sr_reg <= 32'h0000_0000;
      ra_reg <= 32'h0000_0000;
      sp_reg <= 32'h0000_0000;
      k_reg <= 3'd0;
      redirect_pc <= 32'h0000_0000;
      mem_wdata <= 32'h0000_0000;
    end else begin
      case (state_reg)
        S_IDLE: begin
          if (take_evt) begin
            pend_mode_reg <= win_mode;
            ret_flag_reg <= 1'b0;
            nested_reg <= cur_mode >= `ECS_MODE_IRQ_LEVEL_ZERO;
            saved_sr_reg <= sr_reg;
            ra_reg <= cur_pc;
            if (win_mode >= `ECS_MODE_IRQ_LEVEL_ZERO && win_mode <= `ECS_MODE_IRQ_LEVEL_THREE) begin
              redirect_pc <= irq_vector; // RQ5
            end else if (win_mode == `ECS_MODE_NMI) begin
              redirect_pc <= evba_reg + `ECS_VEC_NMI;
            end else if (win_mode == `ECS_MODE_EXC) begin
              redirect_pc <= evba_reg + `ECS_VEC_EXC;
            end else begin
              redirect_pc <= evba_reg + `ECS_VEC_SCALL;
            end
            state_reg <= stack_mode ? S_RDSP : S_DONE; // RQ6 RQ8 RQ10
          end else if (ret_ok) begin
            pend_mode_reg <= cur_mode;
            ret_flag_reg <= 1'b1;
            redirect_pc <= rar_sel; // RQ10
            state_reg <= stack_mode ? S_RDSP : S_DONE;
          end
        end
        S_RDSP: state_reg <= S_GETSP;
        S_GETSP: begin
          sp_reg <= rf_rdata;
          k_reg <= ret_flag_reg ? frame_last : 3'd0;
          state_reg <= ret_flag_reg ? S_MEMR : S_PREP;
        end
        S_PREP: begin
          // Status first, then return address, then the scratch group
          mem_wdata <= (k_reg == 3'd0) ? saved_sr_reg : ra_reg; // RQ6 RQ8
          state_reg <= (k_reg >= 3'd2) ? S_WAITRF : S_MEMW;
        end
        S_WAITRF: begin
          mem_wdata <= rf_rdata; // RQ6
          state_reg <= S_MEMW;
        end
        S_MEMW: if (mem_ack) begin
          sp_reg <= sp_reg - `ECS_WORD_BYTES;
          k_reg <= k_reg + 3'd1;
          state_reg <= (k_reg == frame_last) ? S_SPWR : S_PREP;
        end
        S_MEMR: if (mem_ack) begin
          sp_reg <= sp_reg + `ECS_WORD_BYTES;
          if (k_reg == 3'd1) begin
            redirect_pc <= mem_rdata; // RQ7 RQ8
          end
          if (k_reg == 3'd0) begin
            saved_sr_reg <= mem_rdata;
            state_reg <= S_SPWR;
          end else begin
            k_reg <= k_reg - 3'd1;
          end
        end
        S_SPWR: state_reg <= S_DONE;
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // Memory strobes and core handshakes come from flops; the done cycle
  // keeps the unit busy one extra cycle so a held return is not retaken
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 32'h0000_0000;
      core_stall <= 1'b0;
      redirect_valid <= 1'b0;
      exec_mode <= `ECS_MODE_SUP;
    end else begin
      mem_req <= (state_reg == S_PREP) || (state_reg == S_WAITRF && 1'b1) ||
        (state_reg == S_MEMW && !mem_ack) || (state_reg == S_GETSP && ret_flag_reg) ||
        (state_reg == S_MEMR && !(mem_ack && k_reg == 3'd0));
      if (state_reg == S_PREP && k_reg >= 3'd2) begin
        mem_req <= 1'b0;
      end
      mem_we <= !ret_flag_reg;
      if (state_reg == S_GETSP) begin
        mem_addr <= ret_flag_reg ? rf_rdata : rf_rdata - `ECS_WORD_BYTES;
      end else if (state_reg == S_MEMW && mem_ack) begin
        mem_addr <= sp_reg - (`ECS_WORD_BYTES + `ECS_WORD_BYTES);
      end else if (state_reg == S_MEMR && mem_ack) begin
        mem_addr <= sp_reg + `ECS_WORD_BYTES;
      end
      core_stall <= (state_reg == S_IDLE) ? (take_evt || take_ret) : (state_reg != S_DONE);
      redirect_valid <= (state_reg == S_IDLE && (take_evt || take_ret) && !stack_mode) ||
        state_reg == S_SPWR;
      exec_mode <= cur_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: no wait states, unmapped offsets answer with an error
  wire ev_set_entry = fin_entry;
  wire [`ECS_EV_WIDTH-1:0] ev_set = {fin_entry && (stack_mode ? nested_reg :
    cur_mode >= `ECS_MODE_IRQ_LEVEL_ZERO), fin_ret, ev_set_entry};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `ECS_CTRL_RESET;
      evba_reg <= 32'h0000_0000;
      istat_reg <= {`ECS_EV_WIDTH{1'b0}};
      ien_reg <= {`ECS_EV_WIDTH{1'b0}};
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        prdata <= 32'h0000_0000;
        if (paddr == `ECS_OFS_CTRL) begin
          prdata <= ctrl_reg;
        end else if (paddr == `ECS_OFS_SR) begin
          prdata <= sr_reg;
        end else if (paddr == `ECS_OFS_EVBA) begin
          prdata <= evba_reg;
        end else if (paddr == `ECS_OFS_ISTAT) begin
          prdata <= {29'h0000_0000, istat_reg};
        end else if (paddr == `ECS_OFS_IEN) begin
          prdata <= {29'h0000_0000, ien_reg};
        end else if (paddr == `ECS_OFS_STATE) begin
          prdata <= {24'h00_0000, busy, state_reg, cur_mode};
        end else if (paddr != `ECS_OFS_ICLR) begin
          pslverr <= 1'b1;
        end
      end
      // Variant changes only while idle, which includes the cycle in which an event or return is taken
      if (apb_wr && paddr == `ECS_OFS_CTRL && !busy) begin
        ctrl_reg <= {31'h0000_0000, pwdata[`ECS_CTRL_STACK]};
      end
      if (apb_wr && paddr == `ECS_OFS_EVBA) begin
        evba_reg <= pwdata;
      end
      if (apb_wr && paddr == `ECS_OFS_IEN) begin
        ien_reg <= pwdata[`ECS_EV_WIDTH-1:0];
      end
      // A new event in the clearing cycle survives the clear
      if (apb_wr && paddr == `ECS_OFS_ICLR) begin
        istat_reg <= (istat_reg & ~pwdata[`ECS_EV_WIDTH-1:0]) | ev_set;
      end else begin
        istat_reg <= istat_reg | ev_set;
      end
      irq <= |(istat_reg & ien_reg);
    end
  end
endmodule // ecs_event_unit

// [verilog/ecs_defines.vh]
`ifndef ECS_DEFINES_VH
`define ECS_DEFINES_VH

// Register byte offsets on the APB slave
`define ECS_OFS_CTRL 12'h000
`define ECS_OFS_SR 12'h004
`define ECS_OFS_EVBA 12'h008
`define ECS_OFS_ISTAT 12'h00C
`define ECS_OFS_ICLR 12'h010
`define ECS_OFS_IEN 12'h014
`define ECS_OFS_STATE 12'h018

// Control register fields
`define ECS_CTRL_STACK 0
`define ECS_CTRL_RESET 32'h0000_0000

// Status word fields
`define ECS_SR_MODE_LSB 22
`define ECS_SR_EM 21
`define ECS_SR_IMASK_LSB 17
`define ECS_SR_RESET 32'h0060_0000
`define ECS_SR_SW_MASK 32'h003E_FFFF

// Execution mode codes; a larger code is a higher priority class
`define ECS_MODE_NMI 3'h7
`define ECS_MODE_EXC 3'h6
`define ECS_MODE_IRQ_LEVEL_THREE 3'h5
`define ECS_MODE_IRQ_LEVEL_ZERO 3'h2
`define ECS_MODE_SUP 3'h1
`define ECS_MODE_APP 3'h0

// Handler offsets from the event base for non-vectored classes
`define ECS_VEC_NMI 32'h0000_0010
`define ECS_VEC_EXC 32'h0000_0020
`define ECS_VEC_SCALL 32'h0000_0100

// Register file indices and frame sizes
`define ECS_RF_SP 4'hD
`define ECS_RF_SCRATCH_LO 4'h8
`define ECS_RF_SCRATCH_HI 4'hC
`define ECS_FRAME_IRQ 3'h7
`define ECS_FRAME_EXC 3'h2
`define ECS_WORD_BYTES 32'h0000_0004

// Interrupt event bits
`define ECS_EV_ENTRY 0
`define ECS_EV_RETURN 1
`define ECS_EV_NESTED 2
`define ECS_EV_WIDTH 3

`endif

// [verilog/ecs_arbiter.v]
`timescale 1ns/10ps
`include "ecs_defines.vh"

module ecs_arbiter (
  nmi_req,
  exc_req,
  irq_levels,
  scall_req,
  exception_mask_bit,
  irq_masks,
  cur_mode,
  win_valid,
  win_mode
);
  input wire nmi_req;
  input wire exc_req;
  input wire [3:0] irq_levels;
  input wire scall_req;
  input wire exception_mask_bit;
  input wire [3:0] irq_masks;
  input wire [2:0] cur_mode;
  output reg win_valid;
  output reg [2:0] win_mode;

  integer i;

  // Fixed priority scan, lowest first so the highest source overwrites
  always @* begin
    win_valid = 1'b0;
    win_mode = `ECS_MODE_APP;
    if (scall_req && cur_mode <= `ECS_MODE_SUP) begin
      win_valid = 1'b1;
      win_mode = `ECS_MODE_SUP;
    end
    for (i = 0; i < 4; i = i + 1) begin
      if (irq_levels[i] && !irq_masks[i]) begin // RQ1
        win_valid = 1'b1;
        win_mode = `ECS_MODE_IRQ_LEVEL_ZERO + i[2:0];
      end
    end
    if (exc_req && !exception_mask_bit) begin
      win_valid = 1'b1;
      win_mode = `ECS_MODE_EXC;
    end
    if (nmi_req) begin
      win_valid = 1'b1;
      win_mode = `ECS_MODE_NMI;
    end
    // Only a strictly higher class may preempt the running one; a supervisor call is also taken in supervisor mode
    if (win_valid && win_mode != `ECS_MODE_SUP && win_mode <= cur_mode) begin // RQ2
      win_valid = 1'b0;
    end
  end
endmodule // ecs_arbiter

// [verilog/ecs_regfile.v]
`timescale 1ns/10ps
`include "ecs_defines.vh"

module ecs_regfile (
  pclk,
  presetn,
  shadow_sel,
  we,
  waddr,
  wdata,
  raddr,
  rdata
);
  input wire pclk;
  input wire presetn;
  input wire shadow_sel;
  input wire we;
  input wire [3:0] waddr;
  input wire [31:0] wdata;
  input wire [3:0] raddr;
  output reg [31:0] rdata;

  // Sixteen shared words plus the five banked scratch words
  reg [31:0] mem [0:20]; // RQ12

  // Only the scratch group moves to the bank; the rest stays shared
  function [4:0] phys;
    input [3:0] idx;
    input bank;
    begin
      if (bank && idx >= `ECS_RF_SCRATCH_LO && idx <= `ECS_RF_SCRATCH_HI) begin // RQ16
        phys = {1'b0, idx} + 5'd8; // RQ11
      end else begin
        phys = {1'b0, idx};
      end
    end
  endfunction

  // Storage has no reset; software owns its contents
  always @(posedge pclk) begin
    if (we) begin
      mem[phys(waddr, shadow_sel)] <= wdata;
    end
  end

  // Registered read port
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= mem[phys(raddr, shadow_sel)];
    end
  end
endmodule // ecs_regfile

// [verification/ecs_monitor.sv]
`timescale 1ns/10ps
// Watches the event unit ports; all checks run on the one bus clock
module ecs_monitor (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire nmi_req,
  input wire core_stall,
  input wire redirect_valid,
  input wire [2:0] exec_mode,
  input wire mem_req,
  input wire mem_we,
  input wire [31:0] mem_addr,
  input wire mem_ack
);
  default clocking mon_cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////
  // Bus answers come one cycle after setup and last one cycle
  a_apb_answer: assert property (psel && !penable |=> pready)
    else $error("access phase without ready");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  // Event sequencing
  a_redirect_pulse: assert property (redirect_valid |=> !redirect_valid)
    else $error("redirect longer than one cycle");
  a_mode_reset: assert property ($rose(presetn) |-> exec_mode == 3'h1)
    else $error("mode not supervisor after reset");
  a_nmi_wins: assert property (
    nmi_req && !core_stall && !redirect_valid && exec_mode != 3'h7 |-> ##[1:60] exec_mode == 3'h7)
    else $error("top event not taken");
  // Stack traffic only inside a stalled save or restore, held until answered
  a_mem_stall: assert property (mem_req |-> core_stall)
    else $error("stack access outside stall");
  a_mem_hold: assert property (
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("stack request changed before answer");
  c_bus_error: cover property (pslverr);
  c_stack_word: cover property (mem_req && mem_ack);
  c_top_level: cover property (exec_mode == 3'h5);
endmodule // ecs_monitor

bind ecs_event_unit ecs_monitor ecs_monitor_i (.*);

// [verification/ecs_far_model.sv]
`timescale 1ns/10ps
// Interrupt controller and stack memory on the far side of the unit
module ecs_far_model (
  input wire pclk,
  input wire presetn,
  input wire slow,
  input wire [3:0] src,
  output reg [3:0] irq_levels,
  output reg [31:0] irq_vector,
  input wire mem_req,
  input wire mem_we,
  input wire [31:0] mem_addr,
  input wire [31:0] mem_wdata,
  output reg [31:0] mem_rdata,
  output reg mem_ack
);
  reg [31:0] stack [0:63];
  reg [1:0] wait_cnt;
  // Sources are synchronised, so levels lag the raw requests
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_levels <= 4'h0;
    end else begin
      irq_levels <= src;
    end
  end
  // Vector of the highest pending level
  always @* begin
    casez (irq_levels)
      4'b1???: irq_vector = 32'h0000_20C0;
      4'b01??: irq_vector = 32'h0000_2080;
      4'b001?: irq_vector = 32'h0000_2040;
      default: irq_vector = 32'h0000_2000;
    endcase
  end
  // Slow mode waits three cycles; read data toggles when not answering
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      wait_cnt <= 2'd0;
      mem_rdata <= 32'h0000_0000;
    end else if (mem_req && !mem_ack && wait_cnt >= (slow ? 2'd3 : 2'd0)) begin
      mem_ack <= 1'b1;
      wait_cnt <= 2'd0;
      mem_rdata <= stack[mem_addr[7:2]];
      if (mem_we) begin
        stack[mem_addr[7:2]] <= mem_wdata;
      end
    end else begin
      mem_ack <= 1'b0;
      wait_cnt <= (mem_req && !mem_ack) ? wait_cnt + 2'd1 : 2'd0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule // ecs_far_model

// [verification/ecs_event_unit_bench.sv]
`timescale 1ns/10ps
`include "ecs_defines.vh"
module ecs_event_unit_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rf_we = 1'b0, dbg_enter = 1'b0;
  logic slow = 1'b0, stack_on = 1'b0, e;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, cur_pc = 32'h0, rf_wdata = 32'h0, q, ded_mem = 32'h0;
  logic [3:0] rf_waddr = 4'h0, rf_raddr = 4'h0, src;
  logic [7:0] reqs = 8'h00;
  logic exc_req, nmi_req, scall_req, ret_req;
  logic [6:0] rows [0:3] = '{7'h21, 7'h33, 7'h47, 7'h5F};
  wire [31:0] prdata, rf_rdata, mem_addr, mem_wdata, mem_rdata, redirect_pc, irq_vector;
  wire pready, pslverr, mem_req, mem_we, mem_ack, core_stall, redirect_valid, irq;
  wire [2:0] exec_mode;
  wire [3:0] irq_levels;
  wire irq_level_zero = irq_levels[0];
  wire irq_level_one = irq_levels[1];
  wire irq_level_two = irq_levels[2];
  wire irq_level_three = irq_levels[3];
  int errors = 0, checks_done = 0, cycles = 0;
  assign {ret_req, scall_req, nmi_req, exc_req, src} = reqs;
  ecs_event_unit ecs_event_unit_i (.*);
  ecs_far_model ecs_far_model_i (.pclk(pclk), .presetn(presetn), .slow(slow), .src(src),
    .irq_levels(irq_levels), .irq_vector(irq_vector), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  always #25 pclk = ~pclk;
  // Hang guard; dedicated mode must never touch memory
  always @(posedge pclk) begin
    cycles++;
    if (mem_req === 1'b1 && !stack_on) ded_mem <= ded_mem + 32'h1;
    if (cycles == 20000) begin
      errors++;
      stop_test;
    end
  end
  ////////////////////////////////////////////////////////////
  task stop_test;
    begin
      $display("errors=%0d checks=%0d", errors, checks_done);
      if (errors == 0 && checks_done > 0) begin
        $display("SIMULATION PASSED");
      end else begin
        $display("SIMULATION FAILED");
      end
      $finish;
    end
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    begin
      checks_done++;
      if (got !== exp) begin
        errors++;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // Request held from setup until ready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    begin
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
        @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      {psel, penable} <= 2'b00;
    end
  endtask
  // Raise events, await the redirect, drop them, then look at the mode
  task ev(input logic [7:0] set_r, input logic [7:0] drop_r, input logic [31:0] epc,
      input logic [2:0] emode);
    begin
      @(posedge pclk);
      reqs <= reqs | set_r;
      cur_pc <= 32'hC000_0000 | {24'h0, set_r};
      do begin
        @(posedge pclk);
      end while (redirect_valid !== 1'b1);
      check(redirect_pc, epc);
      reqs <= reqs & ~drop_r;
      @(posedge pclk);
      check({29'h0, exec_mode}, {29'h0, emode});
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    begin
      @(posedge pclk);
      {rf_we, rf_waddr, rf_wdata} <= {1'b1, a, d};
      @(posedge pclk);
      rf_we <= 1'b0;
    end
  endtask
  task rd(input logic [3:0] a, input logic [31:0] exp);
    begin
      @(posedge pclk);
      rf_raddr <= a;
      repeat (2) @(posedge pclk);
      check(rf_rdata, exp);
    end
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check({29'h0, exec_mode}, 32'h1);
    apb(1'b0, `ECS_OFS_SR, 32'h0);
    check(q, `ECS_SR_RESET);
    apb(1'b1, `ECS_OFS_EVBA, 32'h0000_8000);
    apb(1'b1, `ECS_OFS_IEN, 32'h0000_0001);
    apb(1'b0, 12'h01C, 32'h0);
    check({31'h0, e}, 32'h1);
    // One row per level: enter, check masks and interrupt, return
    for (int i = 0; i < 4; i++) begin
      ev(8'h01 << i, 8'h01 << i, 32'h0000_2000 + 32'h40 * i, rows[i][6:4]);
      check({31'h0, irq}, 32'h1);
      apb(1'b1, `ECS_OFS_ICLR, 32'h0000_0007);
      apb(1'b0, `ECS_OFS_SR, 32'h0);
      check(q, {7'h0, rows[i][6:4], 1'b1, rows[i][3:0], 17'h0});
      check({31'h0, irq}, 32'h0);
      ev(8'h80, 8'h80, 32'hC000_0000 | (32'h1 << i), 3'h1);
      apb(1'b0, `ECS_OFS_SR, 32'h0);
      check(q, `ECS_SR_RESET);
    end
    apb(1'b0, `ECS_OFS_ISTAT, 32'h0);
    check(q, 32'h2);
    check({31'h0, irq}, 32'h0);
    // Simultaneous events, preemption and nested returns
    ev(8'h01, 8'h01, 32'h0000_2000, 3'h2);
    ev(8'h24, 8'h24, 32'h0000_8010, 3'h7);
    ev(8'h80, 8'h80, 32'hC000_0024, 3'h2);
    ev(8'h04, 8'h04, 32'h0000_2080, 3'h4);
    ev(8'h80, 8'h80, 32'hC000_0004, 3'h2);
    ev(8'h80, 8'h80, 32'hC000_0001, 3'h1);
    ev(8'h40, 8'h40, 32'h0000_8100, 3'h1);
    ev(8'h80, 8'h80, 32'hC000_0040, 3'h1);
    apb(1'b1, `ECS_OFS_SR, 32'h0);
    ev(8'h10, 8'h10, 32'h0000_8020, 3'h6);
    apb(1'b0, `ECS_OFS_SR, 32'h0);
    check(q, 32'h01A0_0000);
    ev(8'h80, 8'h80, 32'hC000_0010, 3'h1);
    dbg_enter <= 1'b1;
    apb(1'b0, `ECS_OFS_SR, 32'h0);
    dbg_enter <= 1'b0;
    check(q, `ECS_SR_RESET);
    // Banked scratch group at the top level only
    wr(4'h8, 32'hAAAA_0008);
    wr(4'h7, 32'hAAAA_0007);
    ev(8'h08, 8'h08, 32'h0000_20C0, 3'h5);
    wr(4'h8, 32'hBBBB_0008);
    wr(4'h7, 32'hBBBB_0007);
    rd(4'h8, 32'hBBBB_0008);
    ev(8'h80, 8'h80, 32'hC000_0008, 3'h1);
    rd(4'h8, 32'hAAAA_0008);
    rd(4'h7, 32'hBBBB_0007);
    check(ded_mem, 32'h0);
    // Stack variant with a slow memory on entry, prompt on return
    apb(1'b1, `ECS_OFS_CTRL, 32'h0000_0001);
    stack_on = 1'b1;
    slow <= 1'b1;
    wr(4'hD, 32'h0000_0100);
    for (int i = 0; i < 5; i++) wr(4'h8 + i, 32'h1110_0000 + i);
    ev(8'h02, 8'h02, 32'h0000_2040, 3'h3);
    check(ecs_far_model_i.stack[63], `ECS_SR_RESET);
    check(ecs_far_model_i.stack[62], 32'hC000_0002);
    for (int i = 0; i < 5; i++) check(ecs_far_model_i.stack[61 - i], 32'h1110_0000 + i);
    rd(4'hD, 32'h0000_00E4);
    wr(4'h8, 32'hDEAD_0008);
    slow <= 1'b0;
    ev(8'h80, 8'h80, 32'hC000_0002, 3'h1);
    rd(4'h8, 32'h1110_0000);
    rd(4'hD, 32'h0000_0100);
    ev(8'h40, 8'h40, 32'h0000_8100, 3'h1);
    check(ecs_far_model_i.stack[62], 32'hC000_0040);
    ev(8'h80, 8'h80, 32'hC000_0040, 3'h1);
    stop_test;
  end
endmodule // ecs_event_unit_bench
